// File: inc/acq_regs.svh
// register offsets, field positions, reset values and timing counts for the acquisition control
// assumes an 8-bit byte-addressed register port with 16-bit data
`ifndef ACQ_REGS_SVH
`define ACQ_REGS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define OFF_DAC_FIRST    8'h04
`define OFF_DAC_SECOND   8'h08
`define OFF_RESULT       8'h10
`define OFF_STATUS       8'h14
`define OFF_CHAN_SEL     8'h18
`define OFF_RANGE        8'h1c
`define OFF_MODE         8'h20
`define OFF_SOFT_TRIG    8'h24
`define OFF_PACER_LO     8'h28
`define OFF_PACER_HI     8'h2c
`define OFF_CONFIG       8'h30

// ----------------------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------------------
`define RST_CHAN         4'h0
`define RST_RANGE        4'h1
`define RST_MODE         3'h0
`define RST_CONFIG       2'h0
`define CFG_DIFF_BIT     0
`define CFG_SCAN_BIT     1
`define DIFF_MAX_CHAN    4'h7
`define STAT_READY_BIT   0
`define STAT_IRQ_BIT     1

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CLK_SYS_MHZ      250
`define PACER_SRC_MHZ    2
`define PACER_TICK_CYC   (`CLK_SYS_MHZ / `PACER_SRC_MHZ)

`endif

// File: inc/acq_pkg.sv
// types shared by the acquisition control files
// assumes acq_regs.svh for numeric constants
`default_nettype none
package acq_pkg;
  typedef enum logic [2:0] {
    mode_soft_poll  = 3'h0,
    mode_timer_irq  = 3'h1,
    mode_timer_dma  = 3'h2,
    mode_ext_poll   = 3'h3,
    mode_ext_irq    = 3'h4,
    mode_ext_dma    = 3'h5
  } acq_mode_t;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_conv = 2'b01,
    st_done = 2'b11
  } conv_state_t;
endpackage
`default_nettype wire

// File: hw/pacer_cascade.sv
// two cascaded 16-bit down counters clocked from a 2 MHz tick
// tick is made internally as a one-cycle pulse at the pacer source rate
`default_nettype none
`include "acq_regs.svh"
module pacer_cascade #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  // control
  input  wire logic             run,
  input  wire logic [CNT_W-1:0] div_first,
  input  wire logic [CNT_W-1:0] div_second,
  // output
  output logic                  pace_pulse
);
  // --------------------------------------------------------------------------
  // source tick
  // --------------------------------------------------------------------------
  logic [7:0]       tick_cnt_ff;
  logic             tick;
  logic [CNT_W-1:0] first_ff;
  logic [CNT_W-1:0] second_ff;
  logic             first_wrap;

  assign tick = (tick_cnt_ff == 8'(`PACER_TICK_CYC - 1));

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_ff <= 8'h00;
    end else if (!run || tick) begin
      tick_cnt_ff <= 8'h00;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 8'h01;
    end
  end

  // --------------------------------------------------------------------------
  // cascade: second counter steps once per first-counter wrap
  // --------------------------------------------------------------------------
  assign first_wrap = tick && (first_ff <= CNT_W'(1));

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      first_ff <= '0;
    end else if (!run) begin
      first_ff <= div_first;
    end else if (first_wrap) begin
      first_ff <= div_first;
    end else if (tick) begin
      first_ff <= first_ff - CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      second_ff  <= '0;
      pace_pulse <= 1'b0;
    end else begin
      pace_pulse <= run && first_wrap && (second_ff <= CNT_W'(1));
      if (!run) begin
        second_ff <= div_second;
      end else if (first_wrap) begin
        second_ff <= (second_ff <= CNT_W'(1)) ? div_second : second_ff - CNT_W'(1);
      end
    end
  end
endmodule // pacer_cascade
`default_nettype wire

// File: hw/acq_control.sv
// acquisition control: register port, trigger select, scan and result capture
// assumes a synchronous 8-bit address / 16-bit data register port and an
// input converter that answers conv_start with adc_done and adc_value
`default_nettype none
`include "acq_regs.svh"
module acq_control
  import acq_pkg::*;
#(
  parameter int DATA_W = 12,
  parameter int CH_W   = 4
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  // register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [15:0]       reg_wdata,
  output logic [15:0]            reg_rdata,
  // output converters
  output logic [DATA_W-1:0]      output_converter_first,
  output logic [DATA_W-1:0]      output_converter_second,
  // input front end
  output logic [CH_W-1:0]        mux_chan,
  output logic [3:0]             range_code,
  output logic                   diff_mode,
  output logic                   conv_start,
  input  wire logic              adc_done,
  input  wire logic [DATA_W-1:0] adc_value,
  // triggers and transfer
  input  wire logic              ext_trig,
  output logic                   irq_req,
  output logic                   dma_req
);
  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  logic [DATA_W-1:0] dac_first_ff, dac_second_ff;
  logic [CH_W-1:0]   chan_prog_ff, chan_cur_ff;
  logic [3:0]        range_ff;
  acq_mode_t         mode_ff;
  logic [1:0]        config_ff;
  logic [15:0]       pacer_lo_ff, pacer_hi_ff;
  logic [15:0]       result_ff;
  logic              ready_n_ff;
  logic              irq_ff;
  logic              ext_prev_ff;
  conv_state_t       state_ff;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // both the programmed and the live channel take the clamped number
  function automatic logic [CH_W-1:0] clamp_chan(input logic diff,
                                                 input logic [CH_W-1:0] ch);
    return (diff && ch > `DIFF_MAX_CHAN) ? `DIFF_MAX_CHAN : ch;
  endfunction

  logic wr_dac1, wr_dac2, wr_chan, wr_soft, rd_result;
  assign wr_dac1   = reg_wr && hit(reg_addr, `OFF_DAC_FIRST);
  assign wr_dac2   = reg_wr && hit(reg_addr, `OFF_DAC_SECOND);
  assign wr_chan   = reg_wr && hit(reg_addr, `OFF_CHAN_SEL);
  assign wr_soft   = reg_wr && hit(reg_addr, `OFF_SOFT_TRIG);
  assign rd_result = reg_rd && hit(reg_addr, `OFF_RESULT);

  // --------------------------------------------------------------------------
  // output converter codes
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dac_first_ff  <= '0;
      dac_second_ff <= '0;
    end else begin
      if (wr_dac1) dac_first_ff <= reg_wdata[DATA_W-1:0];
      if (wr_dac2) dac_second_ff <= reg_wdata[DATA_W-1:0];
    end
  end
  assign output_converter_first  = dac_first_ff;
  assign output_converter_second = dac_second_ff;

  // --------------------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------------------
  // out-of-range differential channel numbers are clamped when the channel is
  // written, using the differential bit in force at that write
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      chan_prog_ff <= `RST_CHAN;
      range_ff     <= `RST_RANGE;
      mode_ff      <= acq_mode_t'(`RST_MODE);
      config_ff    <= `RST_CONFIG;
      pacer_lo_ff  <= 16'h0000;
      pacer_hi_ff  <= 16'h0000;
    end else if (reg_wr) begin
      if (wr_chan) begin
        chan_prog_ff <= clamp_chan(config_ff[`CFG_DIFF_BIT], reg_wdata[CH_W-1:0]);
      end
      if (hit(reg_addr, `OFF_RANGE)) range_ff <= reg_wdata[3:0];
      if (hit(reg_addr, `OFF_MODE) && reg_wdata[2:0] <= 3'h5)
        mode_ff <= acq_mode_t'(reg_wdata[2:0]);
      if (hit(reg_addr, `OFF_CONFIG)) config_ff <= reg_wdata[1:0];
      if (hit(reg_addr, `OFF_PACER_LO)) pacer_lo_ff <= reg_wdata;
      if (hit(reg_addr, `OFF_PACER_HI)) pacer_hi_ff <= reg_wdata;
    end
  end
  assign range_code = range_ff;
  assign diff_mode  = config_ff[`CFG_DIFF_BIT];

  // --------------------------------------------------------------------------
  // trigger select
  // --------------------------------------------------------------------------
  logic timer_mode, ext_mode, soft_mode, pace_pulse, trig;
  assign soft_mode  = (mode_ff == mode_soft_poll);
  assign timer_mode = (mode_ff == mode_timer_irq) || (mode_ff == mode_timer_dma);
  assign ext_mode   = (mode_ff == mode_ext_poll) || (mode_ff == mode_ext_irq) ||
                      (mode_ff == mode_ext_dma);

  pacer_cascade #(.CNT_W(16)) u_pacer (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .run        (timer_mode),
    .div_first  (pacer_lo_ff),
    .div_second (pacer_hi_ff),
    .pace_pulse (pace_pulse)
  );

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) ext_prev_ff <= 1'b0;
    else          ext_prev_ff <= ext_trig;
  end

  // triggers arriving mid-conversion are dropped; the converter is single-shot
  assign trig = (soft_mode && wr_soft) ||
                (timer_mode && pace_pulse) ||
                (ext_mode && ext_trig && !ext_prev_ff);

  // --------------------------------------------------------------------------
  // conversion sequence and scan
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= st_idle;
    end else begin
      unique case (state_ff)
        st_idle: if (trig) state_ff <= st_conv;
        st_conv: if (adc_done) state_ff <= st_done;
        st_done: state_ff <= st_idle;
        default: state_ff <= st_idle;
      endcase
    end
  end
  assign conv_start = (state_ff == st_idle) && trig;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      chan_cur_ff <= `RST_CHAN;
    end else if (wr_chan || !config_ff[`CFG_SCAN_BIT]) begin
      chan_cur_ff <= wr_chan ? clamp_chan(config_ff[`CFG_DIFF_BIT], reg_wdata[CH_W-1:0])
                             : chan_prog_ff;
    end else if (state_ff == st_done) begin
      chan_cur_ff <= (chan_cur_ff == '0) ? chan_prog_ff : chan_cur_ff - 1'b1;
    end
  end
  assign mux_chan = chan_cur_ff;

  // --------------------------------------------------------------------------
  // result word, ready flag, transfer requests
  // --------------------------------------------------------------------------
  // a new result sets ready over a simultaneous read, so no result is missed
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      result_ff  <= 16'h0000;
      ready_n_ff <= 1'b1;
      irq_ff     <= 1'b0;
    end else if (state_ff == st_conv && adc_done) begin
      result_ff  <= {adc_value, chan_cur_ff};
      ready_n_ff <= 1'b0;
      irq_ff     <= (mode_ff == mode_timer_irq) || (mode_ff == mode_ext_irq);
    end else if (rd_result) begin
      ready_n_ff <= 1'b1;
      irq_ff     <= 1'b0;
    end
  end
  assign irq_req = irq_ff;
  assign dma_req = !ready_n_ff && ((mode_ff == mode_timer_dma) || (mode_ff == mode_ext_dma));

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `OFF_RESULT:   reg_rdata <= result_ff;
        `OFF_STATUS:   reg_rdata <= {14'h0000, irq_ff, ready_n_ff};
        `OFF_DAC_FIRST:  reg_rdata <= {4'h0, dac_first_ff};
        `OFF_DAC_SECOND: reg_rdata <= {4'h0, dac_second_ff};
        `OFF_CHAN_SEL: reg_rdata <= {12'h000, chan_prog_ff};
        `OFF_RANGE:    reg_rdata <= {12'h000, range_ff};
        `OFF_MODE:     reg_rdata <= {13'h0000, mode_ff};
        `OFF_CONFIG:   reg_rdata <= {14'h0000, config_ff};
        `OFF_PACER_LO: reg_rdata <= pacer_lo_ff;
        `OFF_PACER_HI: reg_rdata <= pacer_hi_ff;
        default:       reg_rdata <= 16'h0000;
      endcase
    end
  end
endmodule // acq_control
`default_nettype wire

// File: testbench/adc_model.sv
// input converter model: answers conv_start with adc_done and a tagged value
// assumes the channel is valid on the conv_start cycle
`default_nettype none
module adc_model (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        slow,
  input  wire logic        conv_start,
  input  wire logic [3:0]  mux_chan,
  output logic             adc_done,
  output logic [11:0]      adc_value
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] cnt_ff;
  logic [3:0] ch_ff;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= 5'h00;
      ch_ff <= 4'h0;
      adc_done <= 1'b0;
      adc_value <= 12'h000;
    end else begin
      adc_done <= 1'b0;
      // value is only good with adc_done, so it toggles otherwise
      adc_value <= ~adc_value;
      if (conv_start) begin
        cnt_ff <= slow ? 5'h14 : 5'h02;
        ch_ff <= mux_chan;
      end else if (cnt_ff == 5'h01) begin
        adc_done <= 1'b1;
        adc_value <= {8'hc3, ch_ff};
        cnt_ff <= 5'h00;
      end else if (cnt_ff != 5'h00) begin
        cnt_ff <= cnt_ff - 5'h01;
      end
    end
  end
endmodule // adc_model
`default_nettype wire

// File: testbench/acq_control_checker.sv
// assertions on the acquisition control ports
// assumes binding to acq_control
`default_nettype none
`include "acq_regs.svh"
module acq_control_checker #(
  parameter int DATA_W = 12,
  parameter int CH_W   = 4
) (
  input wire logic              clk_sys,
  input wire logic              reset_n,
  input wire logic [7:0]        reg_addr,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [15:0]       reg_wdata,
  input wire logic [DATA_W-1:0] output_converter_first,
  input wire logic [DATA_W-1:0] output_converter_second,
  input wire logic [CH_W-1:0]   mux_chan,
  input wire logic [3:0]        range_code,
  input wire logic              diff_mode,
  input wire logic              conv_start,
  input wire logic              adc_done,
  input wire logic              irq_req,
  input wire logic              dma_req
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence wr_at(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence
  sequence recent_done;
    $past(adc_done) || $past(adc_done, 2) || $past(adc_done, 3);
  endsequence
  a_dac_first_code: assert property (wr_at(`OFF_DAC_FIRST) |=>
    output_converter_first == $past(reg_wdata[DATA_W-1:0])) else $error("dac first code");
  a_dac_second_code: assert property (wr_at(`OFF_DAC_SECOND) |=>
    output_converter_second == $past(reg_wdata[DATA_W-1:0])) else $error("dac second code");
  a_chan_diff_clamp: assert property (wr_at(`OFF_CHAN_SEL) |=> mux_chan ==
    ((!$past(diff_mode) || $past(reg_wdata[3:0]) <= `DIFF_MAX_CHAN) ?
    $past(reg_wdata[3:0]) : `DIFF_MAX_CHAN)) else $error("chan clamp");
  a_range_write: assert property (wr_at(`OFF_RANGE) |=>
    range_code == $past(reg_wdata[3:0])) else $error("range write");
  a_reset_defaults: assert property ($rose(reset_n) |->
    mux_chan == 4'h0 && range_code == 4'h1) else $error("reset defaults");
  a_conv_start_quiet: assert property (conv_start |=> !conv_start [*2])
    else $error("conv start repeat");
  a_irq_after_done: assert property ($rose(irq_req) |-> recent_done)
    else $error("irq without done");
  a_irq_read_clear: assert property (irq_req && reg_rd && reg_addr == `OFF_RESULT
    && !adc_done |=> !irq_req) else $error("irq not cleared");
  a_dma_after_done: assert property ($rose(dma_req) |-> recent_done or $past(reg_wr))
    else $error("dma without done");
  // a config write reaches the channel one edge later than a channel write
  a_chan_cause: assert property ($changed(mux_chan) |->
    ($past(reg_wr) || $past(reg_wr, 2)) or recent_done)
    else $error("chan moved");
endmodule // acq_control_checker
bind acq_control acq_control_checker #(.DATA_W(DATA_W), .CH_W(CH_W)) u_chk (.*);
`default_nettype wire

// File: testbench/acq_control_tb_top.sv
// self-checking bench for the acquisition control
// assumes adc_model stands in for the input converter
`default_nettype none
`include "acq_regs.svh"
module acq_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic ext_trig = 1'b0, slow = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, d;
  logic [1:0]  f;
  int fails = 0, comparisons = 0, cycles = 0;
  wire logic [15:0] reg_rdata;
  wire logic [11:0] dac1, dac2, adc_value;
  wire logic [3:0]  mux_chan, range_code;
  wire logic diff_mode, conv_start, adc_done, irq_req, dma_req;
  acq_control dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .output_converter_first(dac1), .output_converter_second(dac2), .mux_chan(mux_chan),
    .range_code(range_code), .diff_mode(diff_mode), .conv_start(conv_start),
    .adc_done(adc_done), .adc_value(adc_value), .ext_trig(ext_trig),
    .irq_req(irq_req), .dma_req(dma_req));
  adc_model u_adc (.clk_sys(clk_sys), .reset_n(reset_n), .slow(slow),
    .conv_start(conv_start), .mux_chan(mux_chan), .adc_done(adc_done),
    .adc_value(adc_value));
  always #2 clk_sys = ~clk_sys;
  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      $display("MISMATCH t=%0t run hung", $time);
      finish_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // trig: 0 soft, 1 external edge, 2 pacer; f snapshots irq and dma
  task automatic conv(input int trig, input logic [3:0] ch, output logic [1:0] fl);
    int n;
    logic [15:0] v;
    n = 0;
    if (trig == 0) wr(`OFF_SOFT_TRIG, 16'h0001);
    if (trig == 1) begin
      @(posedge clk_sys) ext_trig <= 1'b1;
      repeat (3) @(posedge clk_sys);
      ext_trig <= 1'b0;
    end
    do begin rd(`OFF_STATUS, v); n++; end while (v[0] !== 1'b0 && n < 600);
    chk({15'h0, v[0]}, 16'h0000, "ready low");
    fl = {irq_req, dma_req};
    rd(`OFF_RESULT, v);
    chk(v, {8'hc3, ch, ch}, "result word");
    chk({15'h0, irq_req}, 16'h0000, "irq after read");
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys) #1;
    chk({12'h0, mux_chan}, 16'h0000, "reset chan");
    chk({12'h0, range_code}, 16'h0001, "reset range");
    rd(`OFF_STATUS, d);
    chk({15'h0, d[0]}, 16'h0001, "not ready");
    wr(`OFF_DAC_FIRST, 16'h0fff);
    wr(`OFF_DAC_SECOND, 16'h0800);
    #1 chk({4'h0, dac1}, 16'h0fff, "dac first");
    chk({4'h0, dac2}, 16'h0800, "dac second");
    wr(`OFF_RANGE, 16'h0009);
    #1 chk({12'h0, range_code}, 16'h0009, "range");
    $display("test registers done");
    conv(0, 4'h0, f);
    rd(`OFF_STATUS, d);
    chk({15'h0, d[0]}, 16'h0001, "ready cleared");
    wr(`OFF_CHAN_SEL, 16'h0005);
    conv(0, 4'h5, f);
    slow <= 1'b1;
    conv(0, 4'h5, f);
    wr(`OFF_CONFIG, 16'h0002);
    wr(`OFF_CHAN_SEL, 16'h0002);
    for (int i = 0; i < 4; i++) conv(0, (i == 3) ? 4'h2 : 4'(2 - i), f);
    $display("test conversions done");
    wr(`OFF_CONFIG, 16'h0001);
    wr(`OFF_CHAN_SEL, 16'h0009);
    #1 chk({11'h0, diff_mode, mux_chan}, 16'h0017, "diff clamp");
    wr(`OFF_MODE, 16'h0003);
    wr(`OFF_SOFT_TRIG, 16'h0001);
    repeat (40) @(posedge clk_sys);
    rd(`OFF_STATUS, d);
    chk({15'h0, d[0]}, 16'h0001, "soft ignored");
    for (int m = 3; m < 7; m++) begin
      wr(`OFF_MODE, 16'(m));
      conv(1, 4'h7, f);
      chk({14'h0, f}, (m == 4) ? 16'h0002 : (m == 3) ? 16'h0000 : 16'h0001, "flags");
    end
    wr(`OFF_PACER_LO, 16'h0002);
    wr(`OFF_PACER_HI, 16'h0002);
    wr(`OFF_MODE, 16'h0001);
    conv(2, 4'h7, f);
    chk({14'h0, f}, 16'h0002, "timer irq");
    wr(`OFF_MODE, 16'h0002);
    conv(2, 4'h7, f);
    chk({14'h0, f}, 16'h0001, "timer dma");
    $display("test modes done");
    finish_test();
  end
endmodule // acq_control_tb_top
`default_nettype wire
